// [src/flp_fetch_lock.sv]
// Purpose: one-way fetch lock fuses and programming pulse control
// Assumes: inputs synchronous to sys_clk; cell array is external, read back on cell_rdata
// Notes: fuse cells modelled as sticky flops loaded from fuse_init once after reset
// Function
// - Instruction lock: no fetch, external load resets
// - Lookahead may block last four internal bytes
// - Data lock: no external access, attempt resets
// - Data lock disables memory dump mode
// - Oscillator fuse enables fail reset
// - Fuses set only, never cleared
// - Fuse status readable at 1FF6H
// - Fuses set by slave writes to locations
// - Each pulse at least 100 us; not enforced, width is (count+1)*144 periods
// - Width source depends on programming mode
// - Width word: bit15 one, count below
// - Pulse lasts (count+1)*144 periods
// - Verify after pulses, mismatch drives low
// - Auto mode: exactly five pulses per word
// - Slave mode repeats while strobe asserted
// - Verify status updated after each pulse
// - Strobe fall latches data, rise ends
`timescale 1ns/1ps
module flp_fetch_lock import flp_pkg::*; #(
    parameter logic [15:0] INT_MEM_TOP = 16'h5FFF,
    parameter logic [15:0] INT_MEM_BASE = 16'h2000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic [15:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    input wire flp_mode_t program_strobe_n_mode,
    input wire logic [7:0] fuse_init,
    input wire flp_bus_req_t bus_req,
    input wire logic osc_fail,
    input wire flp_slave_in_t slave_in,
    input wire logic ext_data_valid,
    input wire logic [15:0] ext_data_addr,
    input wire logic [7:0] ext_data,
    input wire logic word_start,
    input wire logic [15:0] word_data,
    input wire logic [15:0] cell_rdata,
    output logic [15:0] cell_wdata,
    output logic program_strobe_n_enable,
    output logic word_done,
    output logic verify_status_out,
    output logic reset_req,
    output logic dump_allowed,
    output logic ext_instr_block,
    output logic ext_data_block
);
    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_PULSE = 3'b001,
        ST_GAP = 3'b011,
        ST_VERIFY = 3'b010,
        ST_DONE = 3'b110
    } flp_state_t;

    // Elaboration check: the internal memory top must lie above its base (at least two addresses)
    if (INT_MEM_TOP <= INT_MEM_BASE) begin : g_bad_range
        $error("flp_fetch_lock: bad internal memory range");
    end

    function automatic logic [15:0] fix_ppw(input logic [15:0] w);
        fix_ppw = w | (16'h0001 << FLP_PPW_MSB);
    endfunction : fix_ppw

    function automatic logic is_external(input logic [15:0] a);
        is_external = (a < INT_MEM_BASE) || (a > INT_MEM_TOP);
    endfunction : is_external

    logic [7:0] fuse_q, fuse_d;
    logic [15:0] auto_ppw_q, auto_ppw_d;
    logic [15:0] ser_ppw_q, ser_ppw_d;
    logic [15:0] rt_ppw_q, rt_ppw_d;
    logic [15:0] rdata_q, rdata_d;
    logic [15:0] latch_q, latch_d;
    logic [14:0] addr_q, addr_d;
    logic strobe_q, strobe_d;
    logic [2:0] npulse_q, npulse_d;
    logic ver_q, ver_d;
    logic done_q, done_d;
    logic rst_req_q, rst_req_d;
    logic inblk_q, inblk_d;
    logic dblk_q, dblk_d;
    logic dump_q, dump_d;
    logic fuse_loaded_q;
    flp_state_t st_q, st_d;
    logic tmr_start, tmr_en, tmr_done;
    logic [14:0] width_sel;
    logic strobe_fall, cmd_fall;
    logic cmd_prev_q;

    // Width source selected by mode
    always_comb begin
        case (program_strobe_n_mode)
            FLP_MODE_SLAVE: width_sel = rt_ppw_q[14:0]; // Strobe sets the repeats, register the width
            FLP_MODE_AUTO: width_sel = auto_ppw_q[14:0];
            FLP_MODE_SERIAL: width_sel = ser_ppw_q[14:0];
            default: width_sel = rt_ppw_q[14:0];
        endcase
    end

    assign strobe_fall = strobe_q && !slave_in.program_strobe_n;
    // A released strobe ends the word; the gap state reads its level
    assign cmd_fall = cmd_prev_q && !slave_in.command_latch_strobe_n;

    flp_pulse_timer #(.PRESCALE(FLP_PRESCALE)) u_timer (
        .sys_clk(sys_clk),
        .rst(rst),
        .clk_en(clk_en),
        .start(tmr_start),
        .count(width_sel),
        .program_strobe_n_enable(tmr_en),
        .done(tmr_done)
    );

    // Pulse sequencer: slave repeats while strobe low, others fire five pulses
    always_comb begin
        st_d = st_q;
        npulse_d = npulse_q;
        latch_d = latch_q;
        addr_d = addr_q;
        ver_d = ver_q;
        done_d = 1'b0;
        tmr_start = 1'b0;
        strobe_d = slave_in.program_strobe_n;
        case (st_q)
            ST_IDLE: begin
                if (program_strobe_n_mode == FLP_MODE_SLAVE && strobe_fall) begin
                    latch_d = slave_in.pbus;
                    st_d = ST_PULSE;
                    tmr_start = 1'b1;
                end else if (program_strobe_n_mode != FLP_MODE_SLAVE && word_start) begin
                    latch_d = word_data;
                    npulse_d = 3'd0;
                    st_d = ST_PULSE;
                    tmr_start = 1'b1;
                end
            end
            ST_PULSE: begin
                if (tmr_done) begin
                    ver_d = (cell_rdata == latch_q);
                    npulse_d = npulse_q + 3'd1;
                    st_d = ST_GAP;
                end
            end
            ST_GAP: begin
                if (program_strobe_n_mode == FLP_MODE_SLAVE) begin
                    if (slave_in.program_strobe_n) begin
                        st_d = ST_VERIFY;
                    end else begin
                        tmr_start = 1'b1;
                        st_d = ST_PULSE;
                    end
                end else if (npulse_q < 3'(FLP_AUTO_PULSES)) begin
                    tmr_start = 1'b1;
                    st_d = ST_PULSE;
                end else begin
                    st_d = ST_VERIFY;
                end
            end
            ST_VERIFY: begin
                ver_d = (cell_rdata == latch_q);
                done_d = 1'b1;
                addr_d = addr_q + 15'd1;
                st_d = ST_DONE;
            end
            ST_DONE: st_d = ST_IDLE;
            default: st_d = ST_IDLE;
        endcase
        if (program_strobe_n_mode == FLP_MODE_SLAVE && cmd_fall) begin
            addr_d = slave_in.pbus[15:1];
        end
    end

    // Fuses, registers and read data
    always_comb begin
        fuse_d = fuse_loaded_q ? fuse_q : (fuse_q | (fuse_init & FLP_FUSE_MASK));
        auto_ppw_d = auto_ppw_q;
        ser_ppw_d = ser_ppw_q;
        rt_ppw_d = rt_ppw_q;
        rdata_d = 16'h0000;
        // Slave write to a fuse location sets, never clears
        if (program_strobe_n_mode == FLP_MODE_SLAVE && st_q == ST_VERIFY && latch_q[0] == 1'b0) begin
            if (addr_q == FLP_LOC_DEI && latch_q[15:8] == FLP_VAL_DEI) begin
                fuse_d[FLP_BIT_DEI] = 1'b1;
            end
            if (addr_q == FLP_LOC_DED && latch_q[15:8] == FLP_VAL_DED) begin
                fuse_d[FLP_BIT_DED] = 1'b1;
            end
            if (addr_q == FLP_LOC_OFD && latch_q[15:8] == FLP_VAL_OFD) begin
                fuse_d[FLP_BIT_OFD] = 1'b1;
            end
        end
        // Auto mode width taken from external bytes 14H and 15H
        if (program_strobe_n_mode == FLP_MODE_AUTO && ext_data_valid) begin
            if (ext_data_addr == FLP_EXT_PPW_LO) auto_ppw_d = fix_ppw({auto_ppw_q[15:8], ext_data});
            if (ext_data_addr == FLP_EXT_PPW_HI) auto_ppw_d = fix_ppw({ext_data, auto_ppw_q[7:0]});
        end
        if (reg_wr) begin
            case (reg_addr)
                FLP_ADDR_SER_PPW: ser_ppw_d = fix_ppw(reg_wdata);
                FLP_ADDR_RT_PPW: rt_ppw_d = fix_ppw(reg_wdata);
                default: ;
            endcase
        end
        // Fuse register is read only; reserved bits read zero
        if (reg_rd) begin
            case (reg_addr)
                FLP_ADDR_FUSES: rdata_d = {8'h00, fuse_q & FLP_FUSE_MASK};
                FLP_ADDR_AUTO_PPW: rdata_d = auto_ppw_q;
                FLP_ADDR_SER_PPW: rdata_d = ser_ppw_q;
                FLP_ADDR_RT_PPW: rdata_d = rt_ppw_q;
                FLP_ADDR_CTRL: rdata_d = {13'h0000, st_q};
                default: rdata_d = 16'h0000;
            endcase
        end
    end

    // Lock checks; a disallowed access asks for a device reset
    always_comb begin
        inblk_d = fuse_q[FLP_BIT_DEI];
        dblk_d = fuse_q[FLP_BIT_DED];
        dump_d = !fuse_q[FLP_BIT_DED];
        rst_req_d = 1'b0;
        // Lookahead up to four bytes past execution may trip near the top
        if (fuse_q[FLP_BIT_DEI] && bus_req.instr_load && is_external(bus_req.addr)) begin
            rst_req_d = 1'b1;
        end
        if (fuse_q[FLP_BIT_DED] && bus_req.data_acc && is_external(bus_req.addr)) begin
            rst_req_d = 1'b1;
        end
        if (fuse_q[FLP_BIT_OFD] && osc_fail) begin
            rst_req_d = 1'b1;
        end
    end

    // Registers; fuse cells load from fuse_init once after reset
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            fuse_q <= 8'h00;
            fuse_loaded_q <= 1'b0;
            auto_ppw_q <= FLP_PPW_AUTO_RESET;
            ser_ppw_q <= FLP_PPW_SER_RESET;
            rt_ppw_q <= FLP_PPW_RT_RESET;
            rdata_q <= 16'h0000;
            latch_q <= 16'h0000;
            addr_q <= 15'h0000;
            strobe_q <= 1'b1;
            cmd_prev_q <= 1'b1;
            npulse_q <= 3'd0;
            ver_q <= 1'b1;
            done_q <= 1'b0;
            rst_req_q <= 1'b0;
            inblk_q <= 1'b0;
            dblk_q <= 1'b0;
            dump_q <= 1'b0;
            st_q <= ST_IDLE;
        end else if (clk_en) begin
            fuse_loaded_q <= 1'b1;
            fuse_q <= fuse_d;
            auto_ppw_q <= auto_ppw_d;
            ser_ppw_q <= ser_ppw_d;
            rt_ppw_q <= rt_ppw_d;
            rdata_q <= rdata_d;
            latch_q <= latch_d;
            addr_q <= addr_d;
            strobe_q <= strobe_d;
            cmd_prev_q <= slave_in.command_latch_strobe_n;
            npulse_q <= npulse_d;
            ver_q <= ver_d;
            done_q <= done_d;
            rst_req_q <= rst_req_d;
            inblk_q <= inblk_d;
            dblk_q <= dblk_d;
            dump_q <= dump_d;
            st_q <= st_d;
        end
    end

    // Cell data mirrors the latched word; enable comes from the timer flop
    assign cell_wdata = latch_q;
    assign program_strobe_n_enable = tmr_en;
    assign reg_rdata = rdata_q;
    assign word_done = done_q;
    assign verify_status_out = ver_q;
    assign reset_req = rst_req_q;
    assign ext_instr_block = inblk_q;
    assign ext_data_block = dblk_q;
    assign dump_allowed = dump_q;
endmodule : flp_fetch_lock

// [pkg/flp_pkg.sv]
// Purpose: shared constants and types for the fetch lock and programming pulse block
// Assumes: single 50 MHz clock, synchronous active-high reset
// Notes: fuse bit positions, register offsets, pulse timing and modes live here
package flp_pkg;
    // Register offsets on the plain register port
    localparam logic [15:0] FLP_ADDR_FUSES = 16'h1FF6;
    localparam logic [15:0] FLP_ADDR_AUTO_PPW = 16'h1FF8;
    localparam logic [15:0] FLP_ADDR_SER_PPW = 16'h1FFA;
    localparam logic [15:0] FLP_ADDR_RT_PPW = 16'h1FFC;
    localparam logic [15:0] FLP_ADDR_CTRL = 16'h1FFE;
    // Fuse bit positions in the fuse status register
    localparam int FLP_BIT_DEI = 3;
    localparam int FLP_BIT_DED = 2;
    localparam int FLP_BIT_OFD = 0;
    // Slave-mode fuse programming locations and values
    localparam logic [14:0] FLP_LOC_DEI = 15'h0718;
    localparam logic [14:0] FLP_LOC_DED = 15'h0758;
    localparam logic [14:0] FLP_LOC_OFD = 15'h0778;
    localparam logic [7:0] FLP_VAL_DEI = 8'h08;
    localparam logic [7:0] FLP_VAL_DED = 8'h04;
    localparam logic [7:0] FLP_VAL_OFD = 8'h01;
    localparam logic [7:0] FLP_FUSE_MASK = 8'h0D;
    // Auto mode pulse width word location in external memory
    localparam logic [15:0] FLP_EXT_PPW_LO = 16'h0014;
    localparam logic [15:0] FLP_EXT_PPW_HI = 16'h0015;
    // Pulse width word: bit 15 forced set, 14:0 count
    localparam int FLP_PPW_MSB = 15;
    localparam logic [15:0] FLP_PPW_SER_RESET = 16'hFFFF;
    localparam logic [15:0] FLP_PPW_AUTO_RESET = 16'h8000;
    localparam logic [15:0] FLP_PPW_RT_RESET = 16'h8000;
    // Timing
    localparam int FLP_CLK_MHZ = 50;
    localparam int FLP_PRESCALE = 144;
    localparam int FLP_MIN_PULSE_US = 100;
    localparam int FLP_MIN_PULSE_CYC = FLP_MIN_PULSE_US * FLP_CLK_MHZ;
    localparam int FLP_AUTO_PULSES = 5;
    localparam int FLP_LOOKAHEAD = 4;
    // Programming modes
    typedef enum logic [1:0] {
        FLP_MODE_RUN = 2'h0,
        FLP_MODE_SLAVE = 2'h1,
        FLP_MODE_AUTO = 2'h2,
        FLP_MODE_SERIAL = 2'h3
    } flp_mode_t;
    // Bus controller access request
    typedef struct packed {
        logic instr_load;
        logic data_acc;
        logic [15:0] addr;
    } flp_bus_req_t;
    // Slave programming strobes and bus
    typedef struct packed {
        logic program_strobe_n;
        logic command_latch_strobe_n;
        logic [15:0] pbus;
    } flp_slave_in_t;
endpackage : flp_pkg

// [src/flp_pulse_timer.sv]
// Purpose: programming pulse timer, (count+1)*144 oscillator periods
// Assumes: start is a one-cycle pulse while idle
// Notes: enable output held active until count expires
`timescale 1ns/1ps
module flp_pulse_timer import flp_pkg::*; #(
    parameter int PRESCALE = FLP_PRESCALE
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic clk_en,
    input wire logic start,
    input wire logic [14:0] count,
    output logic program_strobe_n_enable,
    output logic done
);
    // Elaboration check: the prescaler must fit its eight-bit down counter
    if (PRESCALE < 1 || PRESCALE > 255) begin : g_bad_prescale
        $error("flp_pulse_timer: PRESCALE out of range");
    end
    logic [7:0] pre_q, pre_d;
    logic [15:0] cnt_q, cnt_d;
    logic en_q, en_d;
    logic done_q, done_d;

    // Prescale by 144, count down pulse_width_count+1 ticks
    always_comb begin
        pre_d = pre_q;
        cnt_d = cnt_q;
        en_d = en_q;
        done_d = 1'b0;
        if (start && !en_q) begin
            en_d = 1'b1;
            cnt_d = {1'b0, count};
            pre_d = 8'(PRESCALE - 1);
        end else if (en_q) begin
            if (pre_q == 8'h00) begin
                pre_d = 8'(PRESCALE - 1);
                if (cnt_q == 16'h0000) begin
                    en_d = 1'b0;
                    done_d = 1'b1;
                end else begin
                    cnt_d = cnt_q - 16'h0001;
                end
            end else begin
                pre_d = pre_q - 8'h01;
            end
        end
    end

    // Registers only
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pre_q <= 8'h00;
            cnt_q <= 16'h0000;
            en_q <= 1'b0;
            done_q <= 1'b0;
        end else if (clk_en) begin
            pre_q <= pre_d;
            cnt_q <= cnt_d;
            en_q <= en_d;
            done_q <= done_d;
        end
    end
    assign program_strobe_n_enable = en_q;
    assign done = done_q;
endmodule : flp_pulse_timer

// [dv/flp_fetch_lock_properties.sv]
// Purpose: port-level checks of the fetch lock and pulse block
// Assumes: one clock domain, clk_en dropped by the bench only while no pulse runs
// Notes: pulse length and pulses per word come from small helper counters
`timescale 1ns/1ps
module flp_fetch_lock_chk import flp_pkg::*; #(
    parameter logic [15:0] INT_MEM_TOP = 16'h5FFF,
    parameter logic [15:0] INT_MEM_BASE = 16'h2000
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic [15:0] reg_addr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    input wire flp_mode_t program_strobe_n_mode,
    input wire flp_bus_req_t bus_req,
    input wire flp_slave_in_t slave_in,
    input wire logic [15:0] cell_rdata,
    input wire logic [15:0] cell_wdata,
    input wire logic program_strobe_n_enable,
    input wire logic word_done,
    input wire logic verify_status_out,
    input wire logic reset_req,
    input wire logic dump_allowed,
    input wire logic ext_instr_block,
    input wire logic ext_data_block
);
    default clocking @(posedge sys_clk); endclocking
    default disable iff (rst);
    logic [15:0] run_q, run_d;
    logic [3:0] np_q, np_d;
    logic pe_q;
    logic ext_a;
    // Anything outside the internal range goes to the external bus
    assign ext_a = (bus_req.addr > INT_MEM_TOP) || (bus_req.addr < INT_MEM_BASE);
    // Run length of the enable and rising edges within one word
    always_comb begin
        run_d = program_strobe_n_enable ? run_q + 16'h0001 : 16'h0000;
        np_d = word_done ? 4'h0 : np_q + {3'h0, program_strobe_n_enable & ~pe_q};
    end
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            run_q <= 16'h0000;
            np_q <= 4'h0;
            pe_q <= 1'b0;
        end else begin
            run_q <= run_d;
            np_q <= np_d;
            pe_q <= program_strobe_n_enable;
        end
    end
    rd_fuse_a: assert property (reg_rd && reg_addr == FLP_ADDR_FUSES
        |=> (reg_rdata & 16'hFFF2) == 16'h0000)
        else $error("fuse readback shows reserved bits");
    rd_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
        else $error("read data outside its cycle");
    instr_lock_a: assert property (ext_instr_block && bus_req.instr_load && ext_a |=> reset_req)
        else $error("external fetch load did not reset");
    data_lock_a: assert property (ext_data_block && bus_req.data_acc && ext_a |=> reset_req)
        else $error("external data access did not reset");
    instr_sticky_a: assert property (ext_instr_block |=> ext_instr_block)
        else $error("instruction lock cleared");
    data_sticky_a: assert property (ext_data_block |=> ext_data_block)
        else $error("data lock cleared");
    dump_off_a: assert property (ext_data_block ##1 ext_data_block |-> !dump_allowed)
        else $error("dump allowed under data lock");
    pulse_len_a: assert property ($fell(program_strobe_n_enable) |-> run_q % FLP_PRESCALE == 0)
        else $error("pulse not a whole number of prescaler periods");
    auto_five_a: assert property (word_done && program_strobe_n_mode == FLP_MODE_AUTO |-> np_q == 4'h5)
        else $error("auto word without five pulses");
    slave_repeat_a: assert property ($fell(program_strobe_n_enable) && program_strobe_n_mode == FLP_MODE_SLAVE
        && !slave_in.program_strobe_n |-> ##[1:2] program_strobe_n_enable)
        else $error("pulse not repeated while strobe low");
    verify_a: assert property (word_done |=> verify_status_out == (cell_rdata == cell_wdata))
        else $error("verify status disagrees with cell");
    cover property (word_done && program_strobe_n_mode == FLP_MODE_AUTO);
    cover property ($fell(program_strobe_n_enable) && !slave_in.program_strobe_n);
    cover property (reset_req);
endmodule : flp_fetch_lock_chk
bind flp_fetch_lock flp_fetch_lock_chk #(.INT_MEM_TOP(INT_MEM_TOP), .INT_MEM_BASE(INT_MEM_BASE)) chk_i (.*);

// [dv/flp_program_strobe_n_model.sv]
// Purpose: external programmer and cell stand-in for slave and verify traffic
// Assumes: pull-ups on the programming bus, so a released bus reads all ones
// Notes: bad_cell makes the cell read back inverted to force a verify failure
`timescale 1ns/1ps
module flp_program_strobe_n_model import flp_pkg::*; (
    input wire logic sys_clk,
    input wire logic program_strobe_n_enable,
    input wire logic [15:0] cell_wdata,
    output flp_slave_in_t slave_in,
    output logic [15:0] cell_rdata
);
    logic bad_cell = 1'b0;
    initial slave_in = '{1'b1, 1'b1, 16'hFFFF};
    initial cell_rdata = 16'hFFFF;
    // Cell takes the word while a pulse is applied
    always @(posedge sys_clk) begin
        if (program_strobe_n_enable) cell_rdata <= bad_cell ? ~cell_wdata : cell_wdata;
    end
    // Command word, then data held steady for as long as the strobe is low
    task automatic slave_word(input logic [15:0] cmd, input logic [15:0] data, input int hold);
        @(posedge sys_clk) slave_in.pbus <= cmd;
        @(posedge sys_clk) slave_in.command_latch_strobe_n <= 1'b0;
        @(posedge sys_clk) slave_in <= '{1'b1, 1'b1, data};
        @(posedge sys_clk) slave_in.program_strobe_n <= 1'b0;
        repeat (hold) @(posedge sys_clk);
        slave_in <= '{1'b1, 1'b1, 16'hFFFF};
    endtask : slave_word
endmodule : flp_program_strobe_n_model

// [dv/flp_testbench.sv]
// Purpose: self-checking bench for the fetch lock and pulse block
// Assumes: clk_en dropped only in the register scenario; fuse cells given through fuse_init
// Notes: pulse counts and widths are measured from program_strobe_n_enable itself
`timescale 1ns/1ps
module testbench import flp_pkg::*;;
    logic sys_clk = 1'b0;
    logic rst = 1'b1;
    logic clk_en = 1'b1;
    logic [15:0] reg_addr = 16'h0000;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    flp_mode_t program_strobe_n_mode = FLP_MODE_RUN;
    logic [7:0] fuse_init = 8'h00;
    flp_bus_req_t bus_req = '0;
    logic osc_fail = 1'b0;
    logic ext_data_valid = 1'b0;
    logic [15:0] ext_data_addr = 16'h0000;
    logic [7:0] ext_data = 8'h00;
    logic word_start = 1'b0;
    logic [15:0] word_data = 16'h0000;
    flp_slave_in_t slave_in;
    logic [15:0] reg_rdata, cell_rdata, cell_wdata;
    logic program_strobe_n_enable, word_done, verify_status_out, reset_req, dump_allowed, ext_instr_block, ext_data_block;
    int num_errors = 0;
    int n_compared = 0;
    int cyc = 0;
    int n_pulse = 0;
    int cur_len = 0;
    int last_len = 0;
    logic pe_q = 1'b0;
    logic [14:0] locs [3] = '{FLP_LOC_DEI, FLP_LOC_DED, FLP_LOC_OFD};
    logic [7:0] vals [3] = '{FLP_VAL_DEI, FLP_VAL_DED, FLP_VAL_OFD};
    always #10 sys_clk = ~sys_clk;
    flp_fetch_lock uut (.*);
    flp_program_strobe_n_model pm (.*);
    // Pulse counting and pulse length
    always @(posedge sys_clk) begin
        if (program_strobe_n_enable === 1'b1 && pe_q !== 1'b1) n_pulse++;
        if (program_strobe_n_enable === 1'b1) cur_len++;
        else if (pe_q === 1'b1) begin
            last_len = cur_len;
            cur_len = 0;
        end
        pe_q = program_strobe_n_enable;
    end
    // Hang guard, well above the expected run of about 10000 cycles
    always @(posedge sys_clk) begin
        if (++cyc == 30000) begin
            num_errors++;
            end_sim();
        end
    end
    task automatic end_sim();
        if (num_errors == 0 && n_compared > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : end_sim
    task automatic chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            num_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic restart(input flp_mode_t m, input logic [7:0] f);
        @(posedge sys_clk) rst <= 1'b1;
        program_strobe_n_mode <= m;
        fuse_init <= f;
        repeat (8) @(posedge sys_clk);
        rst <= 1'b0;
        repeat (3) @(posedge sys_clk);
    endtask : restart
    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge sys_clk) reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge sys_clk) reg_wr <= 1'b0;
    endtask : wr
    task automatic rd_chk(input logic [15:0] a, input logic [15:0] exp, input string nm);
        @(posedge sys_clk) reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge sys_clk) reg_rd <= 1'b0;
        #1 chk(nm, reg_rdata, exp);
    endtask : rd_chk
    task automatic bus_try(input logic i, input logic d, input logic [15:0] a, input logic o, input logic exp);
        @(posedge sys_clk) bus_req <= '{i, d, a};
        osc_fail <= o;
        @(posedge sys_clk) bus_req <= '0;
        osc_fail <= 1'b0;
        #1 chk("reset_req", {15'h0000, reset_req}, {15'h0000, exp});
    endtask : bus_try
    task automatic wait_done();
        for (int i = 0; i < 4000 && word_done !== 1'b1; i++) @(posedge sys_clk);
        chk("done", {15'h0000, word_done}, 16'h0001);
        repeat (2) @(posedge sys_clk);
        #1;
    endtask : wait_done
    task automatic word_run(input logic [15:0] d, input int len, input logic ok);
        n_pulse = 0;
        @(posedge sys_clk) word_start <= 1'b1;
        word_data <= d;
        @(posedge sys_clk) word_start <= 1'b0;
        wait_done();
        chk("pulses", 16'(n_pulse), 16'h0005);
        chk("width", 16'(last_len), 16'(len));
        chk("verify", {15'h0000, verify_status_out}, {15'h0000, ok});
        chk("cell data", cell_wdata, d);
    endtask : word_run
    // Cell fuses gate external fetch, data and oscillator reset; internal use is free
    task automatic lock_scn();
        for (int f = 0; f < 2; f++) begin
            for (int j = 0; j < 3; j++) begin
                restart(FLP_MODE_RUN, f ? 8'hFF : 8'h00);
                rd_chk(FLP_ADDR_FUSES, f ? 16'h000D : 16'h0000, "fuses");
                chk("locks", {14'h0000, ext_instr_block, ext_data_block}, f ? 16'h0003 : 16'h0000);
                chk("dump", {15'h0000, dump_allowed}, {15'h0000, f == 0});
                bus_try(1'b1, 1'b1, 16'h3000, 1'b0, 1'b0);
                bus_try(j == 0, j == 1, 16'h8000, j == 2, f == 1);
            end
        end
    endtask : lock_scn
    // Read-only fuses, unmapped read, width defaults and forced top bit
    task automatic reg_scn();
        restart(FLP_MODE_RUN, 8'hFF);
        wr(FLP_ADDR_FUSES, 16'h0000);
        rd_chk(FLP_ADDR_FUSES, 16'h000D, "fuses kept");
        rd_chk(16'h1234, 16'h0000, "unmapped");
        rd_chk(FLP_ADDR_SER_PPW, FLP_PPW_SER_RESET, "serial width");
        rd_chk(FLP_ADDR_AUTO_PPW, FLP_PPW_AUTO_RESET, "auto width");
        wr(FLP_ADDR_RT_PPW, 16'h0003);
        rd_chk(FLP_ADDR_RT_PPW, 16'h8003, "width top bit");
        // A frozen clock enable must swallow a write
        @(posedge sys_clk) clk_en <= 1'b0;
        wr(FLP_ADDR_RT_PPW, 16'h0007);
        @(posedge sys_clk) clk_en <= 1'b1;
        rd_chk(FLP_ADDR_RT_PPW, 16'h8003, "frozen write");
        word_run(16'hA5A5, 576, 1'b1);
    endtask : reg_scn
    // Serial width from its register, auto width from external bytes
    task automatic width_scn();
        restart(FLP_MODE_SERIAL, 8'h00);
        wr(FLP_ADDR_SER_PPW, 16'h0001);
        word_run(16'h5A5A, 288, 1'b1);
        restart(FLP_MODE_AUTO, 8'h00);
        @(posedge sys_clk) ext_data_valid <= 1'b1;
        ext_data_addr <= FLP_EXT_PPW_LO;
        ext_data <= 8'h02;
        @(posedge sys_clk) ext_data_addr <= FLP_EXT_PPW_HI;
        ext_data <= 8'h00;
        @(posedge sys_clk) ext_data_valid <= 1'b0;
        rd_chk(FLP_ADDR_AUTO_PPW, 16'h8002, "auto width");
        word_run(16'h1357, 432, 1'b1);
        pm.bad_cell = 1'b1;
        word_run(16'h2468, 432, 1'b0);
        pm.bad_cell = 1'b0;
    endtask : width_scn
    // Slave fuse writes, repeat while strobe low, verify low then back high
    task automatic slave_scn();
        logic [7:0] acc;
        acc = 8'h00;
        restart(FLP_MODE_SLAVE, 8'h00);
        wr(FLP_ADDR_RT_PPW, 16'h8000);
        for (int i = 0; i < 3; i++) begin
            pm.slave_word({locs[i], 1'b1}, {vals[i], 8'h00}, 20);
            wait_done();
            acc = acc | vals[i];
            rd_chk(FLP_ADDR_FUSES, {8'h00, acc}, "fuse set");
        end
        chk("locks", {14'h0000, ext_instr_block, dump_allowed}, 16'h0002);
        pm.bad_cell = 1'b1;
        n_pulse = 0;
        pm.slave_word(16'h0101, 16'h1234, 330);
        wait_done();
        chk("repeats", 16'(n_pulse), 16'h0003);
        chk("verify", {15'h0000, verify_status_out}, 16'h0000);
        pm.bad_cell = 1'b0;
        pm.slave_word(16'h0103, 16'h4321, 20);
        wait_done();
        chk("verify", {15'h0000, verify_status_out}, 16'h0001);
    endtask : slave_scn
    // Main sequence
    initial begin
        restart(FLP_MODE_RUN, 8'h00);
        lock_scn();
        reg_scn();
        width_scn();
        slave_scn();
        end_sim();
    end
endmodule : testbench
